// [common/par_pkg.sv]
/*
 * Package for the process alarm and relay block: address map, field
 * layouts, alarm type codes, reset values and timing constants.
 * Assumes a single 20 MHz clock and a plain strobe register port.
 */
package par_pkg;

   localparam int NUM_CH    = 18;
   localparam int NUM_ALM   = 5;
   localparam int NUM_SLOT  = NUM_CH * NUM_ALM;
   localparam int NUM_RELAY = 12;
   localparam int NUM_DIN   = 6;

   // Timing
   localparam int CLK_PERIOD_NS  = 50;
   localparam int SECOND_NS      = 1000000000;
   localparam int SECOND_CYC     = SECOND_NS / CLK_PERIOD_NS;
   localparam int REFLASH_MS     = 500;
   localparam int REFLASH_CYC    = (REFLASH_MS * 1000000) / CLK_PERIOD_NS;
   localparam int RATE_WIN_MAX_S = 600;

   // Address map, byte addresses on a 12-bit port
   localparam logic [11:0] A_GLOBAL   = 12'h800;
   localparam logic [11:0] A_CH_EN    = 12'h804;
   localparam logic [11:0] A_RLY_EN   = 12'h808;
   localparam logic [11:0] A_RLY_MODE = 12'h80C;
   localparam logic [11:0] A_RLY_FS   = 12'h810;
   localparam logic [11:0] A_RLY_OOR  = 12'h814;
   localparam logic [11:0] A_RLY_ACK  = 12'h818;
   localparam logic [11:0] A_STATUS   = 12'h81C;
   localparam logic [11:0] A_RLY_OUT  = 12'h820;
   localparam logic [11:0] A_CMD      = 12'h824;
   // Slot region: addr[11]=0, slot index addr[10:4], field addr[3:2]
   localparam logic [1:0]  F_CTRL     = 2'h0;
   localparam logic [1:0]  F_LIMIT    = 2'h1;
   localparam logic [1:0]  F_TIME     = 2'h2;
   localparam logic [1:0]  F_STATE    = 2'h3;

   // Global register bits
   localparam int G_MASTER  = 0;
   localparam int G_MUTE    = 1;
   localparam int G_NOTIFY  = 2;
   localparam int G_REC_ACC = 3;
   localparam int G_RLY_EN  = 4;
   // Command bits
   localparam int C_ACK     = 0;
   localparam int C_RESET   = 1;
   localparam int C_REJ_CLR = 2;

   localparam logic [4:0]  GLOBAL_RST = 5'h00;

   // Slot alarm types
   localparam logic [2:0] T_NONE  = 3'h0;
   localparam logic [2:0] T_HIGH  = 3'h1;
   localparam logic [2:0] T_LOW   = 3'h2;
   localparam logic [2:0] T_RATE  = 3'h3;
   localparam logic [2:0] T_ABN   = 3'h4;
   localparam logic [2:0] T_TRUE  = 3'h5;
   localparam logic [2:0] T_FALSE = 3'h6;

   // Relay styles
   localparam logic [1:0] M_NORMAL  = 2'h0;
   localparam logic [1:0] M_LATCH   = 2'h1;
   localparam logic [1:0] M_REFLASH = 2'h2;

   // Status colours
   localparam logic [1:0] S_GREEN = 2'h0;
   localparam logic [1:0] S_AMBER = 2'h1;
   localparam logic [1:0] S_RED   = 2'h2;

   typedef struct packed {
      logic [3:0] contact;
      logic       rec;
      logic       notify;
      logic       en;
      logic [2:0] kind;
   } par_slot_cfg_t;

   localparam par_slot_cfg_t SLOT_CFG_RST = '0;

   typedef struct packed {
      logic [4:0]         ch;
      logic signed [15:0] value;
      logic               abnormal;
   } par_sample_t;

   typedef struct packed {
      logic [1:0] color;
      logic       audible;
      logic       relay_alarm;
   } par_status_t;

endpackage : par_pkg

// [hdl/par_top.sv]
/*
 * Alarm evaluation and relay drive for the process recorder.
 * Samples arrive as one-cycle strobes from the input channels; each
 * sample spends five clocks evaluating its channel's slots. Assumes
 * samples spaced at least six clocks apart (busy shows the engine
 * state) and acknowledge/reset pins asynchronous to clk.
 */
module par_top #(
   parameter int TICK_CYC    = par_pkg::SECOND_CYC,
   parameter int REFLASH_CYC = par_pkg::REFLASH_CYC
) (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic [11:0]         addr,
   input  wire logic [31:0]         wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output      logic [31:0]         rdata,
   input  wire logic                smp_valid,
   input  wire par_pkg::par_sample_t smp,
   output      logic                busy,
   input  wire logic                ack_pin,
   input  wire logic                reset_pin,
   output      logic [11:0]         relay_drive,
   output      par_pkg::par_status_t status,
   output      logic                notify_req,
   output      logic [6:0]          notify_slot,
   output      logic                record_req
);

   localparam int NS = par_pkg::NUM_SLOT;
   localparam int NR = par_pkg::NUM_RELAY;

   function automatic logic [6:0] addr_slot(input logic [11:0] a);
      return a[10:4];
   endfunction : addr_slot

   function automatic logic slot_region(input logic [11:0] a);
      return (a[11] == 1'b0) && (a[10:4] < 7'(NS));
   endfunction : slot_region

   // Configuration storage
   par_pkg::par_slot_cfg_t cfg_ctrl [NS];
   logic signed [15:0]     cfg_sp   [NS];
   logic signed [15:0]     cfg_db   [NS];
   logic [15:0]            cfg_dly  [NS];
   logic [9:0]             cfg_win  [NS];
   logic [4:0]             global_q;
   logic [17:0]            ch_en_q;
   logic [11:0]            rly_en_q;
   logic [23:0]            rly_mode_q;
   logic [11:0]            rly_fs_q;
   logic [11:0]            rly_oor_q;
   logic [11:0]            rly_ack_q;
   logic                   reject_q;

   // Slot run state
   logic [NS-1:0]          cond_q;
   logic [NS-1:0]          act_q;
   logic [NS-1:0]          ref_ok_q;
   logic [15:0]            start_t  [NS];
   logic signed [15:0]     ref_v    [NS];
   logic [15:0]            ref_t    [NS];

   // Timebase
   logic [31:0]            presc_q;
   logic [15:0]            sec_q;

   // Pin synchronisers and command pulses
   logic [1:0]             s1_q;
   logic [1:0]             s2_q;
   logic [1:0]             s3_q;
   logic [1:0]             stab_q;
   logic [1:0]             stab_d;
   logic                   ack_evt;
   logic                   rst_evt;

   typedef enum {ST_IDLE, ST_EVAL} par_state_t;
   par_state_t             state_q;
   par_pkg::par_sample_t   smp_q;
   logic [6:0]             base_q;
   logic [2:0]             k_q;
   logic [11:0]            rise_q;
   logic                   any_rise_q;

   wire cmd_wr = wr && (addr == par_pkg::A_CMD);

   // Register writes
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NS; i++)
            cfg_ctrl[i] <= par_pkg::SLOT_CFG_RST;
         global_q   <= par_pkg::GLOBAL_RST;
         ch_en_q    <= '0;
         rly_en_q   <= '0;
         rly_mode_q <= '0;
         rly_fs_q   <= '0;
         rly_oor_q  <= '0;
         rly_ack_q  <= '0;
      end
      else if (wr)
      begin
         if (slot_region(addr) && addr[3:2] == par_pkg::F_CTRL)
            cfg_ctrl[addr_slot(addr)] <= wdata[9:0];
         case (addr)
            par_pkg::A_GLOBAL:   global_q   <= wdata[4:0];
            par_pkg::A_CH_EN:    ch_en_q    <= wdata[17:0];
            par_pkg::A_RLY_EN:   rly_en_q   <= wdata[11:0];
            par_pkg::A_RLY_MODE: rly_mode_q <= wdata[23:0];
            par_pkg::A_RLY_FS:   rly_fs_q   <= wdata[11:0];
            par_pkg::A_RLY_OOR:  rly_oor_q  <= wdata[11:0];
            par_pkg::A_RLY_ACK:  rly_ack_q  <= wdata[11:0];
            default:             ;
         endcase
      end
   end

   // Limits and times: plain storage, meaningless until written
   wire lim_bad = $signed(wdata[31:16]) > $signed(wdata[15:0]);
   always_ff @(posedge clk)
   begin
      if (wr && slot_region(addr) && addr[3:2] == par_pkg::F_LIMIT && !lim_bad)
      begin
         cfg_sp[addr_slot(addr)] <= wdata[15:0];
         cfg_db[addr_slot(addr)] <= wdata[31:16];
      end
      if (wr && slot_region(addr) && addr[3:2] == par_pkg::F_TIME)
      begin
         cfg_dly[addr_slot(addr)] <= wdata[15:0];
         // Window clipped so the rate check never spans over 600 s
         cfg_win[addr_slot(addr)] <= (wdata[25:16] > 10'(par_pkg::RATE_WIN_MAX_S)) ?
                                     10'(par_pkg::RATE_WIN_MAX_S) : wdata[25:16];
      end
   end

   // Rejected limit write flag; a new rejection wins over the clear
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         reject_q <= 1'b0;
      else if (wr && slot_region(addr) && addr[3:2] == par_pkg::F_LIMIT && lim_bad)
         reject_q <= 1'b1;
      else if (cmd_wr && wdata[par_pkg::C_REJ_CLR])
         reject_q <= 1'b0;
   end

   // Read port
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rdata <= '0;
      else if (!rd)
         rdata <= '0;
      else if (slot_region(addr))
         case (addr[3:2])
            par_pkg::F_CTRL:  rdata <= {22'h0, cfg_ctrl[addr_slot(addr)]};
            par_pkg::F_LIMIT: rdata <= {cfg_db[addr_slot(addr)], cfg_sp[addr_slot(addr)]};
            par_pkg::F_TIME:  rdata <= {6'h0, cfg_win[addr_slot(addr)],
                                        cfg_dly[addr_slot(addr)]};
            default:          rdata <= {30'h0, act_q[addr_slot(addr)],
                                        cond_q[addr_slot(addr)]};
         endcase
      else
         case (addr)
            par_pkg::A_GLOBAL:   rdata <= {27'h0, global_q};
            par_pkg::A_CH_EN:    rdata <= {14'h0, ch_en_q};
            par_pkg::A_RLY_EN:   rdata <= {20'h0, rly_en_q};
            par_pkg::A_RLY_MODE: rdata <= {8'h0, rly_mode_q};
            par_pkg::A_RLY_FS:   rdata <= {20'h0, rly_fs_q};
            par_pkg::A_RLY_OOR:  rdata <= {20'h0, rly_oor_q};
            par_pkg::A_RLY_ACK:  rdata <= {20'h0, rly_ack_q};
            par_pkg::A_STATUS:   rdata <= {27'h0, reject_q, status};
            par_pkg::A_RLY_OUT:  rdata <= {20'h0, relay_drive};
            default:             rdata <= '0;
         endcase
   end

   // One-second tick and seconds count
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         presc_q <= '0;
         sec_q   <= '0;
      end
      else if (presc_q == 32'(TICK_CYC - 1))
      begin
         presc_q <= '0;
         sec_q   <= sec_q + 16'h0001;
      end
      else
         presc_q <= presc_q + 32'h0000_0001;
   end

   // Pin inputs: a level counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         stab_q <= '0;
      end
      else
      begin
         s1_q   <= {reset_pin, ack_pin};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         stab_q <= stab_d;
      end
   end

   always_comb
   begin
      for (int p = 0; p < 2; p++)
         stab_d[p] = (s2_q[p] == s3_q[p]) ? s3_q[p] : stab_q[p];
   end

   assign ack_evt = (stab_d[0] && !stab_q[0]) || (cmd_wr && wdata[par_pkg::C_ACK]);
   assign rst_evt = (stab_d[1] && !stab_q[1]) || (cmd_wr && wdata[par_pkg::C_RESET]);

   // Slot evaluation for the slot under the engine
   wire [6:0]              idx   = base_q + {4'h0, k_q};
   par_pkg::par_slot_cfg_t cf;
   logic signed [16:0]     sp;
   logic signed [16:0]     db;
   logic signed [16:0]     v;
   logic signed [16:0]     diff;
   logic [15:0]            age;
   logic                   en_ok;
   logic                   rebase;
   logic                   cond_n;
   logic                   act_n;

   always_comb
   begin
      cf     = cfg_ctrl[idx];
      sp     = 17'(cfg_sp[idx]);
      db     = 17'(cfg_db[idx]);
      v      = 17'(smp_q.value);
      diff   = v - 17'(ref_v[idx]);
      age    = sec_q - ref_t[idx];
      rebase = !ref_ok_q[idx] || (age >= {6'h0, cfg_win[idx]});
      en_ok  = cf.en && ch_en_q[smp_q.ch - 5'd1] && global_q[par_pkg::G_MASTER];
      case (cf.kind)
         par_pkg::T_HIGH:  cond_n = cond_q[idx] ? (v >= sp - db) : (v > sp);
         par_pkg::T_LOW:   cond_n = cond_q[idx] ? (v <= sp + db) : (v < sp);
         par_pkg::T_RATE:  cond_n = ref_ok_q[idx] &&
                                    ((sp >= 0) ? (diff > sp) : (diff < sp));
         par_pkg::T_ABN:   cond_n = smp_q.abnormal;
         par_pkg::T_TRUE:  cond_n = (smp_q.value != 16'h0000);
         par_pkg::T_FALSE: cond_n = (smp_q.value == 16'h0000);
         default:          cond_n = 1'b0;
      endcase
      if (!en_ok)
         cond_n = 1'b0;
      act_n = cond_n && (cond_q[idx] ? (sec_q - start_t[idx]) >= cfg_dly[idx]
                                     : cfg_dly[idx] == 16'h0000);
   end
   // Dead band on high release: low release mirrors it

   // Evaluation engine
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q    <= ST_IDLE;
         smp_q      <= '0;
         base_q     <= '0;
         k_q        <= '0;
         cond_q     <= '0;
         act_q      <= '0;
         ref_ok_q   <= '0;
         rise_q     <= '0;
         any_rise_q <= 1'b0;
         notify_req <= 1'b0;
         notify_slot <= '0;
         record_req <= 1'b0;
      end
      else
      begin
         rise_q     <= '0;
         any_rise_q <= 1'b0;
         notify_req <= 1'b0;
         record_req <= 1'b0;
         case (state_q)
            ST_IDLE:
               if (smp_valid && smp.ch >= 5'd1 && smp.ch <= 5'(par_pkg::NUM_CH))
               begin
                  smp_q   <= smp;
                  base_q  <= 7'(smp.ch - 5'd1) * 7'(par_pkg::NUM_ALM);
                  k_q     <= '0;
                  state_q <= ST_EVAL;
               end
            ST_EVAL:
            begin
               cond_q[idx] <= cond_n;
               act_q[idx]  <= act_n;
               if (cf.kind == par_pkg::T_RATE && rebase)
                  ref_ok_q[idx] <= 1'b1;
               if (act_n && !act_q[idx])
               begin
                  any_rise_q <= 1'b1;
                  if (cf.contact >= 4'd1 && cf.contact <= 4'(NR))
                     rise_q[cf.contact - 4'd1] <= 1'b1;
                  notify_slot <= idx;
                  notify_req  <= cf.notify && global_q[par_pkg::G_NOTIFY];
                  record_req  <= cf.rec && global_q[par_pkg::G_REC_ACC];
               end
               if (k_q == 3'(par_pkg::NUM_ALM - 1))
                  state_q <= ST_IDLE;
               k_q <= k_q + 3'd1;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Start times and rate references
   always_ff @(posedge clk)
   begin
      if (state_q == ST_EVAL)
      begin
         if (cond_n && !cond_q[idx])
            start_t[idx] <= sec_q;
         if (cf.kind == par_pkg::T_RATE && rebase)
         begin
            ref_v[idx] <= smp_q.value;
            ref_t[idx] <= sec_q;
         end
      end
   end

   assign busy = (state_q != ST_IDLE);

   // Contact demand from every live slot
   logic [11:0] alarm_any;
   logic        slot_live;
   always_comb
   begin
      alarm_any = '0;
      slot_live = 1'b0;
      for (int i = 0; i < NS; i++)
      begin
         slot_live = act_q[i] && cfg_ctrl[i].en && global_q[par_pkg::G_MASTER] &&
                     ch_en_q[i / par_pkg::NUM_ALM];
         if (slot_live && cfg_ctrl[i].contact >= 4'd1 && cfg_ctrl[i].contact <= 4'(NR))
            alarm_any[cfg_ctrl[i].contact - 4'd1] = 1'b1;
      end
   end

   // Relay contacts
   logic [11:0] rly_act;
   genvar r;
   generate
      for (r = 0; r < NR; r++)
      begin : g_rly
         logic [1:0]  mode;
         logic        hold_q;
         logic        ackd_q;
         logic        drop_q;
         logic [31:0] flash_q;
         logic        live_q;
         assign mode = rly_mode_q[2*r +: 2];

         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               hold_q  <= 1'b0;
               ackd_q  <= 1'b0;
               drop_q  <= 1'b0;
               flash_q <= '0;
               live_q  <= 1'b0;
            end
            else
            begin
               live_q  <= alarm_any[r];
               // Latch: new alarm wins over release
               if (alarm_any[r])
                  hold_q <= 1'b1;
               else if (ack_evt || rst_evt)
                  hold_q <= 1'b0;
               if (rise_q[r])
                  ackd_q <= 1'b0;
               else if (ack_evt && rly_ack_q[r])
                  ackd_q <= 1'b1;
               if (rise_q[r])
                  drop_q <= 1'b0;
               else if (rst_evt && rly_oor_q[r])
                  drop_q <= 1'b1;
               if (rise_q[r] && mode == par_pkg::M_REFLASH && alarm_any[r] && live_q)
                  flash_q <= 32'(REFLASH_CYC);
               else if (flash_q != '0)
                  flash_q <= flash_q - 32'h0000_0001;
            end
         end

         always_comb
         begin
            case (mode)
               par_pkg::M_NORMAL:  rly_act[r] = alarm_any[r] && !ackd_q;
               par_pkg::M_LATCH:   rly_act[r] = alarm_any[r] || hold_q;
               par_pkg::M_REFLASH: rly_act[r] = alarm_any[r] && (flash_q == '0);
               default:            rly_act[r] = alarm_any[r];
            endcase
            if (drop_q || !rly_en_q[r] || !global_q[par_pkg::G_RLY_EN])
               rly_act[r] = 1'b0;
         end

         // Coil energised on alarm, or off on alarm when fail-safe
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               relay_drive[r] <= 1'b0;
            else
               relay_drive[r] <= rly_en_q[r] && global_q[par_pkg::G_RLY_EN] &&
                                 (rly_act[r] ^ rly_fs_q[r]);
         end
      end
   endgenerate

   // Sound silencing: a new alarm re-arms the sound over an acknowledge
   logic silenced_q;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         silenced_q <= 1'b0;
      else if (any_rise_q)
         silenced_q <= 1'b0;
      else if (ack_evt)
         silenced_q <= 1'b1;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         status <= '{color: par_pkg::S_RED, audible: 1'b0, relay_alarm: 1'b0};
      else
      begin
         if (!global_q[par_pkg::G_MASTER] || |act_q)
            status.color <= par_pkg::S_RED;
         else if (global_q[par_pkg::G_MUTE])
            status.color <= par_pkg::S_AMBER;
         else
            status.color <= par_pkg::S_GREEN;
         status.audible     <= global_q[par_pkg::G_MASTER] && |act_q &&
                               !global_q[par_pkg::G_MUTE] && !silenced_q;
         status.relay_alarm <= |rly_act;
      end
   end

endmodule : par_top

// [testbench/par_assertions.sv]
/* Checker for the alarm relay block, watching only its top ports.
   Assumes the register master follows the strobe port contract. */
module par_assertions (
   input wire logic                 clk,
   input wire logic                 rst_b,
   input wire logic [11:0]          addr,
   input wire logic [31:0]          wdata,
   input wire logic                 wr,
   input wire logic                 rd,
   input wire logic [31:0]          rdata,
   input wire logic                 busy,
   input wire logic [11:0]          relay_drive,
   input wire par_pkg::par_status_t status,
   input wire logic                 notify_req,
   input wire logic [6:0]           notify_slot,
   input wire logic                 record_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0]  glb_q;
   logic [11:0] ren_q;
   // Shadow of the global and relay enable registers
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         glb_q <= 5'h0;
         ren_q <= 12'h0;
      end
      else if (wr && addr == par_pkg::A_GLOBAL)
         glb_q <= wdata[4:0];
      else if (wr && addr == par_pkg::A_RLY_EN)
         ren_q <= wdata[11:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_off_red; !glb_q[0] [*4] |-> status.color == par_pkg::S_RED; endproperty
   a_off_red: assert property (p_off_red) else $error("red missing with master off");
   property p_amber; status.color == par_pkg::S_AMBER |-> glb_q[1] || $past(glb_q[1]); endproperty
   a_amber: assert property (p_amber) else $error("amber without mute");
   property p_notify; notify_req |-> $past(glb_q[2] && busy); endproperty
   a_notify: assert property (p_notify) else $error("notify without enable");
   property p_slot; notify_req |-> notify_slot < 7'h5A; endproperty
   a_slot: assert property (p_slot) else $error("notify slot out of range");
   property p_rec; record_req |-> $past(glb_q[3] && busy); endproperty
   a_rec: assert property (p_rec) else $error("record without accept");
   property p_busy; $rose(busy) |-> busy [*5] ##1 !busy; endproperty
   a_busy: assert property (p_busy) else $error("evaluation not five cycles");
   property p_rly; (relay_drive & ~ren_q & ~$past(ren_q)) == 12'h0; endproperty
   a_rly: assert property (p_rly) else $error("disabled contact driven");
   property p_rd; !$past(rd) |-> rdata == 32'h0; endproperty
   a_rd: assert property (p_rd) else $error("read data outside read slot");
endmodule : par_assertions

bind par_top par_assertions u_chk (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .busy,
   .relay_drive, .status, .notify_req, .notify_slot, .record_req);

// [testbench/par_src.sv]
/* Model of the measured input channels feeding samples.
   Assumes send is called right after a rising clock edge. */
module par_src (
   input wire logic            clk,
   input wire logic            busy,
   output logic                smp_valid,
   output par_pkg::par_sample_t smp
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      smp_valid = 1'h0;
      smp = '0;
   end
   task automatic send(input logic [4:0] ch, input logic [15:0] v);
      int n;
      n = 0;
      while (busy === 1'h1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      smp_valid <= 1'h1;
      smp <= {ch, v, 1'h0};
      @(posedge clk);
      smp_valid <= 1'h0;
      // Released bus must not keep showing the old sample
      smp <= ~smp;
      repeat (12) @(posedge clk);
   endtask : send
endmodule : par_src

// [testbench/par_top_bench.sv]
/* Self-checking bench for the alarm relay block.
   Drives registers, pins and the sample model; counts are shortened. */
module par_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk = 1'h0;
   logic                 rst_b = 1'h0;
   logic [11:0]          addr = 12'h0;
   logic [31:0]          wdata = 32'h0;
   logic                 wr = 1'h0;
   logic                 rd = 1'h0;
   logic                 ack_pin = 1'h0;
   logic                 reset_pin = 1'h0;
   logic [31:0]          rdata;
   logic                 smp_valid;
   par_pkg::par_sample_t smp;
   logic                 busy;
   logic [11:0]          relay_drive;
   par_pkg::par_status_t status;
   logic                 notify_req;
   logic                 record_req;
   logic [6:0]           notify_slot;
   int                   error_cnt = 0;
   int                   n_checks = 0;
   int                   n_ntf = 0;
   int                   n_rec = 0;
   int                   cyc = 0;
   logic [31:0]          rs = 32'hD15FE0A4;
   always #25 clk = ~clk;
   par_top #(.TICK_CYC(20), .REFLASH_CYC(4)) uut (.clk, .rst_b, .addr, .wdata, .wr, .rd,
      .rdata, .smp_valid, .smp, .busy, .ack_pin, .reset_pin, .relay_drive, .status,
      .notify_req, .notify_slot, .record_req);
   par_src src (.clk, .busy, .smp_valid, .smp);
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      n_ntf <= n_ntf + int'(notify_req);
      n_rec <= n_rec + int'(record_req);
      if (cyc == 5000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   function automatic logic [11:0] sa(input int s, input logic [1:0] f);
      return {1'h0, 7'(s), f, 2'h0};
   endfunction : sa
   // Enable, notify and record all set
   function automatic logic [31:0] ctl(input logic [2:0] k, input logic [3:0] c);
      return {22'h0, c, 3'h7, k};
   endfunction : ctl
   function automatic logic expc(input logic [2:0] k, input int sp, input int v);
      case (k)
         par_pkg::T_HIGH:  return v > sp;
         par_pkg::T_LOW:   return v < sp;
         par_pkg::T_TRUE:  return v != 0;
         par_pkg::T_FALSE: return v == 0;
         default:          return 1'h0;
      endcase
   endfunction : expc
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      @(posedge clk);
   endtask : wreg
   task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 chk(rdata & m, e);
      @(posedge clk);
   endtask : rchk
   task automatic pins(input logic [1:0] p);
      {reset_pin, ack_pin} <= p;
      repeat (3) @(posedge clk);
      {reset_pin, ack_pin} <= 2'h0;
      repeat (12) @(posedge clk);
   endtask : pins
   initial
   begin : main
      logic [23:0] kinds;
      int          sp;
      int          v;
      int          r;
      kinds = {3'h0, 3'h6, 3'h6, 3'h5, 3'h2, 3'h2, 3'h1, 3'h1};
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      chk(status.color, par_pkg::S_RED);
      wreg(par_pkg::A_CH_EN, 32'h3FFFF);
      wreg(par_pkg::A_RLY_EN, 32'h7);
      wreg(par_pkg::A_RLY_MODE, 32'h4);
      wreg(par_pkg::A_RLY_FS, 32'h4);
      wreg(par_pkg::A_GLOBAL, 32'h1F);
      repeat (4) @(posedge clk);
      chk(status.color, par_pkg::S_AMBER);
      chk(relay_drive, 12'h4);
      wreg(par_pkg::A_GLOBAL, 32'h1D);
      repeat (4) @(posedge clk);
      chk(status.color, par_pkg::S_GREEN);
      wreg(sa(5, par_pkg::F_LIMIT), 32'h0014000A);
      rchk(par_pkg::A_STATUS, 32'h10, 32'h10);
      wreg(par_pkg::A_CMD, 32'h4);
      rchk(par_pkg::A_STATUS, 32'h10, 32'h0);
      wreg(sa(55, par_pkg::F_TIME), 32'h03E80000);
      rchk(sa(55, par_pkg::F_TIME), 32'h03FF0000, 32'h02580000);
      $display("status and register tests done");
      for (int i = 0; i < 8; i++)
      begin
         sp = int'(rnd() % 500);
         v = kinds[i*3 +: 3] > 3'h4 ? int'(rnd() % 2) : sp + int'(rnd() % 3) - 1;
         wreg(sa(i * 5, par_pkg::F_LIMIT), 32'(sp));
         wreg(sa(i * 5, par_pkg::F_TIME), 32'h0);
         wreg(sa(i * 5, par_pkg::F_CTRL), ctl(kinds[i*3 +: 3], 4'h0));
         src.send(5'(i + 1), 16'(v));
         rchk(sa(i * 5, par_pkg::F_STATE), 32'h3, {2{expc(kinds[i*3 +: 3], sp, v)}});
      end
      $display("type tests done");
      wreg(sa(45, par_pkg::F_LIMIT), 32'h000A00C8);
      wreg(sa(45, par_pkg::F_TIME), 32'h0);
      wreg(sa(45, par_pkg::F_CTRL), ctl(par_pkg::T_HIGH, 4'h1));
      wreg(sa(46, par_pkg::F_LIMIT), 32'h0000012C);
      wreg(sa(46, par_pkg::F_TIME), 32'h0);
      wreg(sa(46, par_pkg::F_CTRL), ctl(par_pkg::T_HIGH, 4'h2));
      v = n_ntf;
      r = n_rec;
      src.send(5'hA, 16'h012D);
      chk(relay_drive, 12'h7);
      chk(32'(n_ntf - v), 32'h2);
      chk(32'(n_rec - r), 32'h2);
      chk(notify_slot, 7'h2E);
      chk({status.relay_alarm, status.audible}, 2'h3);
      pins(2'h1);
      chk({status.color, status.audible}, {par_pkg::S_RED, 1'h0});
      src.send(5'hA, 16'h00BE);
      chk(relay_drive, 12'h7);
      src.send(5'hA, 16'h00BD);
      chk(relay_drive, 12'h6);
      pins(2'h2);
      chk(relay_drive, 12'h4);
      $display("relay tests done");
      wreg(sa(50, par_pkg::F_LIMIT), 32'h0);
      wreg(sa(50, par_pkg::F_TIME), 32'h1);
      wreg(sa(50, par_pkg::F_CTRL), ctl(par_pkg::T_HIGH, 4'h0));
      src.send(5'hB, 16'h0005);
      rchk(sa(50, par_pkg::F_STATE), 32'h3, 32'h1);
      repeat (45) @(posedge clk);
      src.send(5'hB, 16'h0005);
      rchk(sa(50, par_pkg::F_STATE), 32'h3, 32'h3);
      wreg(sa(55, par_pkg::F_LIMIT), 32'hA);
      wreg(sa(55, par_pkg::F_CTRL), ctl(par_pkg::T_RATE, 4'h0));
      src.send(5'hC, 16'h0);
      src.send(5'hC, 16'hB);
      rchk(sa(55, par_pkg::F_STATE), 32'h3, 32'h3);
      wreg(par_pkg::A_CH_EN, 32'h0);
      src.send(5'hA, 16'h012D);
      rchk(sa(45, par_pkg::F_STATE), 32'h2, 32'h0);
      $display("delay and enable tests done");
      report_and_stop();
   end
endmodule : par_top_bench
